// >>> hdl/adc_ctrl_regs.svh
// Register addresses, field positions, reset values and timing counts
// Assumes inclusion by the control module and its bench; the package does not read it
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH
`define ADC_ADDR_MODE      32'hfffff200
`define ADC_ADDR_TIMING    32'hfffff201
`define ADC_ADDR_CHANNEL   32'hfffff202
`define ADC_ADDR_TRIG_SRC  32'hfffff203
`define ADC_ADDR_CMP_MODE  32'hfffff204
`define ADC_ADDR_CMP_THR   32'hfffff205
`define ADC_MODE_RESET     8'h00
`define ADC_TIMING_RESET   8'h00
`define ADC_TRIG_SRC_RESET 8'h00
`define ADC_MODE_BUSY_BIT  0
`define ADC_MODE_WMASK     8'hfe
`define ADC_SRC_WMASK      8'h03
`define ADC_CONV_UNIT      9'h01f
`define ADC_STAB_CODE0     9'h010
`define ADC_STAB_CODE1     9'h01f
`define ADC_STAB_CODE2     9'h02f
`define ADC_STAB_OTHER     9'h032
`endif

// >>> hdl/adc_ctrl_pkg.sv
// Types shared by the converter control block and its bench
// Assumes adc_ctrl_regs.svh holds the register numbers; enum encodings stand here
package adc_ctrl_pkg;
    typedef enum logic [1:0] {
        OP_CONT_SELECT = 2'h0,
        OP_CONT_SCAN   = 2'h1,
        OP_FORBIDDEN   = 2'h2,
        OP_ONESHOT     = 2'h3
    } op_mode_type;
    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_FALL = 2'h1,
        EDGE_RISE = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_sel_type;
    typedef enum logic [1:0] {
        SRC_EXT_PIN = 2'h0,
        SRC_TIMER0  = 2'h1,
        SRC_TIMER1  = 2'h2,
        SRC_NONE    = 2'h3
    } trig_src_type;
    typedef struct packed {
        logic         conversion_enable;
        logic         spare;
        op_mode_type  op_mode;
        edge_sel_type trig_edge_sel;
        logic         trigger_mode_sel;
        logic         busy_flag;
    } mode_ctrl_type;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  mask;
    } reg_req_type;
    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_STAB    = 2'h1,
        ST_CONVERT = 2'h3,
        ST_WAIT    = 2'h2
    } conv_state_type;
endpackage : adc_ctrl_pkg

// >>> hdl/adc_mode_and_timing_control.sv
// Mode and conversion-timing control of a 10-bit SAR converter
// Assumes a CPU byte/bit register port and a trigger pin from outside
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

// Contract
// - Mode register eight bits, byte/bit access, zero reset
// - Bit zero is read-only busy flag
// - Enable bit low stops all conversion
// - Operation mode bits pick select/scan/one-shot
// - Edge bits pick none/falling/rising/both edges
// - Trigger mode bit: software or hardware
// - Busy flag high throughout a conversion
// - Software mode: busy write restarts conversion
// - Hardware mode: busy write returns to waiting
// - Timing register eight bits, zero reset
// - Conversion lasts (code+1)*31 clocks
// - Enable rise waits code-dependent stabilization delay
// - Enable starts conversion or trigger wait
// - Source field picks pin, timer0 or timer1
module adc_mode_and_timing_control
(
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    input  wire adc_ctrl_pkg::reg_req_type req,
    output logic [7:0]                     rd_data,
    input  wire logic                      ext_trigger_pin,
    input  wire logic                      timer_compare0_event,
    input  wire logic                      timer_compare1_event,
    output logic                           busy,
    output logic                           conv_start,
    output logic                           conv_done
);
    adc_ctrl_pkg::mode_ctrl_type  mode;
    adc_ctrl_pkg::mode_ctrl_type  next_mode;
    logic [7:0]                   timing;
    logic [7:0]                   next_timing;
    logic [7:0]                   trig_src;
    logic [7:0]                   next_trig_src;
    logic [7:0]                   next_rd_data;
    adc_ctrl_pkg::conv_state_type state;
    adc_ctrl_pkg::conv_state_type next_state;
    logic [8:0]                   count;
    logic [8:0]                   next_count;
    logic                         next_conv_start;
    logic                         next_conv_done;
    logic                         pin_meta;
    logic                         pin_sync;
    logic                         pin_prev;
    logic                         edge_hit;
    logic                         trig_hit;
    logic                         abort_wr;

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (data & mask);
    endfunction : merge

    function automatic logic [8:0] conv_cycles(input logic [3:0] code);
        conv_cycles = 9'(({5'h00, code} + 9'h001) * `ADC_CONV_UNIT);
    endfunction : conv_cycles

    function automatic logic [8:0] stab_cycles(input logic [3:0] code);
        unique case (code)
            4'h0:    stab_cycles = `ADC_STAB_CODE0;
            4'h1:    stab_cycles = `ADC_STAB_CODE1;
            4'h2:    stab_cycles = `ADC_STAB_CODE2;
            default: stab_cycles = `ADC_STAB_OTHER;
        endcase
    endfunction : stab_cycles

    // Writes that disturb a conversion in flight; channel and compare
    // registers live elsewhere, only their write strobe matters here
    always_comb
    begin
        abort_wr = req.wr && (req.addr == `ADC_ADDR_MODE || req.addr == `ADC_ADDR_TRIG_SRC ||
                              req.addr == `ADC_ADDR_CHANNEL || req.addr == `ADC_ADDR_CMP_MODE ||
                              req.addr == `ADC_ADDR_CMP_THR);
    end

    // Register group
    always_comb
    begin
        next_mode     = mode;
        next_timing   = timing;
        next_trig_src = trig_src;
        next_rd_data  = rd_data;
        if (req.wr && req.addr == `ADC_ADDR_MODE)
            next_mode = merge(mode, req.wdata, req.mask & `ADC_MODE_WMASK);
        if (req.wr && req.addr == `ADC_ADDR_TIMING)
            next_timing = merge(timing, req.wdata, req.mask);
        if (req.wr && req.addr == `ADC_ADDR_TRIG_SRC)
            next_trig_src = merge(trig_src, req.wdata, req.mask & `ADC_SRC_WMASK);
        // The busy bit is live state, never a stored copy
        next_mode.busy_flag = (next_state == adc_ctrl_pkg::ST_CONVERT);
        if (req.rd)
        begin
            unique case (req.addr)
                `ADC_ADDR_MODE:     next_rd_data = {mode[7:1], busy};
                `ADC_ADDR_TIMING:   next_rd_data = timing;
                `ADC_ADDR_TRIG_SRC: next_rd_data = trig_src;
                default:            next_rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode     <= `ADC_MODE_RESET;
            timing   <= `ADC_TIMING_RESET;
            trig_src <= `ADC_TRIG_SRC_RESET;
            rd_data  <= 8'h00;
        end
        else
        begin
            mode     <= next_mode;
            timing   <= next_timing;
            trig_src <= next_trig_src;
            rd_data  <= next_rd_data;
        end
    end

    // Trigger pin: two stages, then a third for edge memory
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end
        else
        begin
            pin_meta <= ext_trigger_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    always_comb
    begin
        unique case (mode.trig_edge_sel)
            adc_ctrl_pkg::EDGE_NONE: edge_hit = 1'b0;
            adc_ctrl_pkg::EDGE_FALL: edge_hit = pin_prev & ~pin_sync;
            adc_ctrl_pkg::EDGE_RISE: edge_hit = pin_sync & ~pin_prev;
            adc_ctrl_pkg::EDGE_BOTH: edge_hit = pin_sync ^ pin_prev;
        endcase
        unique case (adc_ctrl_pkg::trig_src_type'(trig_src[1:0]))
            adc_ctrl_pkg::SRC_EXT_PIN: trig_hit = edge_hit;
            adc_ctrl_pkg::SRC_TIMER0:  trig_hit = timer_compare0_event;
            adc_ctrl_pkg::SRC_TIMER1:  trig_hit = timer_compare1_event;
            adc_ctrl_pkg::SRC_NONE:    trig_hit = 1'b0;
        endcase
    end

    // Conversion sequencer; reacts to register contents one cycle after a write
    always_comb
    begin
        next_state      = state;
        next_count      = count;
        next_conv_start = 1'b0;
        next_conv_done  = 1'b0;
        if (!mode.conversion_enable)
            next_state = adc_ctrl_pkg::ST_IDLE;
        else
        begin
            unique case (state)
                adc_ctrl_pkg::ST_IDLE:
                begin
                    next_state = adc_ctrl_pkg::ST_STAB;
                    next_count = stab_cycles(timing[3:0]) - 9'h001;
                end
                adc_ctrl_pkg::ST_STAB:
                begin
                    if (count != 9'h000)
                        next_count = count - 9'h001;
                    else if (!mode.trigger_mode_sel)
                    begin
                        next_state      = adc_ctrl_pkg::ST_CONVERT;
                        next_count      = conv_cycles(timing[3:0]) - 9'h001;
                        next_conv_start = 1'b1;
                    end
                    else
                        next_state = adc_ctrl_pkg::ST_WAIT;
                end
                adc_ctrl_pkg::ST_WAIT:
                begin
                    if (mode.trigger_mode_sel && trig_hit)
                    begin
                        next_state      = adc_ctrl_pkg::ST_CONVERT;
                        next_count      = conv_cycles(timing[3:0]) - 9'h001;
                        next_conv_start = 1'b1;
                    end
                end
                adc_ctrl_pkg::ST_CONVERT:
                begin
                    if (abort_wr && mode.trigger_mode_sel)
                        next_state = adc_ctrl_pkg::ST_WAIT;
                    else if (abort_wr || (count == 9'h000 &&
                             mode.op_mode != adc_ctrl_pkg::OP_ONESHOT))
                    begin
                        // Continuous modes chain straight into the next conversion
                        next_count      = conv_cycles(timing[3:0]) - 9'h001;
                        next_conv_start = 1'b1;
                        next_conv_done  = !abort_wr;
                    end
                    else if (count == 9'h000)
                    begin
                        next_state     = adc_ctrl_pkg::ST_WAIT;
                        next_conv_done = 1'b1;
                    end
                    else
                        next_count = count - 9'h001;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state      <= adc_ctrl_pkg::ST_IDLE;
            count      <= 9'h000;
            busy       <= 1'b0;
            conv_start <= 1'b0;
            conv_done  <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            count      <= next_count;
            busy       <= (next_state == adc_ctrl_pkg::ST_CONVERT);
            conv_start <= next_conv_start;
            conv_done  <= next_conv_done;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence ext_fall_armed;
        state == adc_ctrl_pkg::ST_WAIT && mode.conversion_enable && mode.trigger_mode_sel
            && trig_src[1:0] == 2'h0 && mode.trig_edge_sel == adc_ctrl_pkg::EDGE_FALL;
    endsequence
    sequence pin_falls;
        pin_prev && !pin_sync;
    endsequence
    sequence ext_rise_armed;
        state == adc_ctrl_pkg::ST_WAIT && mode.conversion_enable && mode.trigger_mode_sel
            && trig_src[1:0] == 2'h0 && mode.trig_edge_sel == adc_ctrl_pkg::EDGE_RISE;
    endsequence
    sequence pin_rises;
        pin_sync && !pin_prev;
    endsequence
    // Last counted cycle of a conversion that no write disturbs
    sequence conv_last;
        state == adc_ctrl_pkg::ST_CONVERT && count == 9'h000 && !abort_wr
            && mode.conversion_enable;
    endsequence

    busy_tracks_state_a: assert property (busy == (state == adc_ctrl_pkg::ST_CONVERT))
        else $error("busy flag disagrees with conversion state");
    busy_read_live_a: assert property (req.rd && req.addr == `ADC_ADDR_MODE
        |=> rd_data[0] == $past(busy))
        else $error("mode read does not show busy");
    busy_write_ignored_a: assert property (req.wr && req.addr == `ADC_ADDR_MODE
        && req.mask[0] && req.wdata[0] && next_state != adc_ctrl_pkg::ST_CONVERT
        |=> !mode.busy_flag)
        else $error("busy bit took written value");
    disable_stops_a: assert property (!mode.conversion_enable
        |=> state == adc_ctrl_pkg::ST_IDLE ##1 !busy)
        else $error("converter ran while disabled");
    stab_load_a: assert property (state == adc_ctrl_pkg::ST_IDLE && mode.conversion_enable
        |=> state == adc_ctrl_pkg::ST_STAB && count == stab_cycles(timing[3:0]) - 9'h001)
        else $error("stabilization delay loaded wrong");
    conv_length_a: assert property (conv_start
        |-> busy && count == conv_cycles(timing[3:0]) - 9'h001)
        else $error("conversion length loaded wrong");
    sw_start_a: assert property (state == adc_ctrl_pkg::ST_STAB && count == 9'h000
        && mode.conversion_enable && !mode.trigger_mode_sel |=> conv_start && busy)
        else $error("software mode did not start after delay");
    sw_abort_a: assert property (state == adc_ctrl_pkg::ST_CONVERT && abort_wr
        && mode.conversion_enable && !mode.trigger_mode_sel |=> conv_start && !conv_done)
        else $error("software abort did not restart");
    hw_abort_a: assert property (state == adc_ctrl_pkg::ST_CONVERT && abort_wr
        && mode.conversion_enable && mode.trigger_mode_sel
        |=> state == adc_ctrl_pkg::ST_WAIT && !busy)
        else $error("hardware abort did not return to wait");
    ext_fall_start_a: assert property (ext_fall_armed and pin_falls |=> conv_start)
        else $error("falling pin edge missed");
    ext_rise_start_a: assert property (ext_rise_armed and pin_rises |=> conv_start)
        else $error("rising pin edge missed");
    edge_none_quiet_a: assert property (state == adc_ctrl_pkg::ST_WAIT
        && trig_src[1:0] == 2'h0 && mode.trig_edge_sel == adc_ctrl_pkg::EDGE_NONE
        |=> !conv_start)
        else $error("pin edge taken with detection off");
    timer0_start_a: assert property (state == adc_ctrl_pkg::ST_WAIT
        && mode.conversion_enable && mode.trigger_mode_sel && trig_src[1:0] == 2'h1
        && timer_compare0_event |=> conv_start && busy)
        else $error("timer event 0 did not start");
    oneshot_stop_a: assert property (conv_last ##0 mode.op_mode == adc_ctrl_pkg::OP_ONESHOT
        |=> state == adc_ctrl_pkg::ST_WAIT && conv_done && !busy)
        else $error("one-shot did not stop after one conversion");
    chain_next_a: assert property (conv_last ##0 mode.op_mode != adc_ctrl_pkg::OP_ONESHOT
        |=> conv_start && conv_done)
        else $error("continuous mode did not chain");
endmodule : adc_mode_and_timing_control

// >>> verif/tb.sv
// Self-checking bench for the converter mode and timing control block
// Assumes the package, register header and design are compiled before this file
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

module tb;
    logic                      clk = 1'b0;
    logic                      arst_n = 1'b0;
    adc_ctrl_pkg::reg_req_type req = '0;
    logic [7:0]                rd_data;
    logic                      ext_trigger_pin = 1'b0;
    logic                      timer_compare0_event = 1'b0;
    logic                      timer_compare1_event = 1'b0;
    logic                      busy;
    logic                      conv_start;
    logic                      conv_done;
    int                        failures = 0;
    int                        checks_done = 0;
    int                        cycles = 0;
    int                        cnt = 0;
    int                        lo;
    int                        hi;
    logic                      rd_pend = 1'b0;
    logic                      pin_q = 1'b0;
    logic                      mute = 1'b0;
    logic [7:0]                exp_rd[$];
    int                        gap_lo[$];
    int                        gap_hi[$];
    int                        exp_done[$];
    int                        codes[4] = '{0, 1, 2, 15};
    int                        stab[4] = '{16, 31, 47, 50};

    adc_mode_and_timing_control u_dut (.clk, .arst_n, .req, .rd_data, .ext_trigger_pin,
        .timer_compare0_event, .timer_compare1_event, .busy, .conv_start, .conv_done);

    always #12.5 clk = ~clk;

    task automatic fail(input string msg);
        failures++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask : fail

    task automatic print_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // Every access idles one cycle so no strobe is assigned twice in a step
    task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d,
                       input logic [7:0] m);
        req <= '{wr: w, rd: ~w, addr: a, wdata: d, mask: m};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask : acc

    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        acc(1'b0, a, 8'h00, 8'hff);
    endtask : rd

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        acc(1'b1, a, d, 8'hff);
    endtask : wr

    task automatic note_start(input int l, input int h);
        gap_lo.push_back(l);
        gap_hi.push_back(h);
    endtask : note_start

    task automatic drain(input int n);
        for (int i = 0; i < n && gap_lo.size() != 0; i++)
            @(posedge clk);
        if (gap_lo.size() != 0)
            fail("conversion start missing");
    endtask : drain

    // Disabling during a conversion may or may not pulse a restart, so starts are muted
    task automatic stop;
        mute = 1'b1;
        wr(`ADC_ADDR_MODE, 8'h00);
        repeat (4) @(posedge clk);
        mute = 1'b0;
        rd(`ADC_ADDR_MODE, 8'h00);
    endtask : stop

    task automatic pulse(input logic sel);
        if (sel)
            timer_compare1_event <= 1'b1;
        else
            timer_compare0_event <= 1'b1;
        @(posedge clk);
        timer_compare0_event <= 1'b0;
        timer_compare1_event <= 1'b0;
        @(posedge clk);
    endtask : pulse

    task automatic edge_pin(input logic level, input logic hit);
        if (hit)
        begin
            note_start(1, 6);
            exp_done.push_back(31);
        end
        ext_trigger_pin <= level;
        repeat (45) @(posedge clk);
        drain(4);
    endtask : edge_pin

    // Result watcher: cnt counts edges since the last write, trigger or start
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail("timeout");
            print_verdict();
        end
        if (rd_pend)
        begin
            checks_done++;
            if (exp_rd.size() == 0)
                fail("read without note");
            else if (rd_data !== exp_rd.pop_front())
                fail("read data");
        end
        rd_pend <= req.rd;
        if (conv_start === 1'b1 && !mute)
        begin
            checks_done++;
            if (gap_lo.size() == 0)
                fail("conversion start");
            else
            begin
                lo = gap_lo.pop_front();
                hi = gap_hi.pop_front();
                if (cnt < lo || cnt > hi)
                    fail($sformatf("start after %0d cycles", cnt));
            end
        end
        // Aborted or disabled conversions must never report completion
        if (conv_done === 1'b1)
        begin
            checks_done++;
            if (exp_done.size() == 0)
                fail("conversion done");
            else if (cnt != exp_done.pop_front())
                fail($sformatf("done after %0d cycles", cnt));
        end
        if (req.wr || timer_compare0_event || timer_compare1_event || conv_start === 1'b1
            || ext_trigger_pin != pin_q)
            cnt = 1;
        else
            cnt++;
        pin_q = ext_trigger_pin;
    end

    initial
    begin
        logic [7:0] v;
        logic [7:0] m;
        int         n;
        void'($urandom(15051));
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(`ADC_ADDR_MODE, 8'h00);
        rd(`ADC_ADDR_TIMING, 8'h00);
        rd(`ADC_ADDR_TRIG_SRC, 8'h00);
        rd(32'hfffff210, 8'h00);
        repeat (6)
        begin
            v = 8'($urandom());
            wr(`ADC_ADDR_MODE, v & 8'h7f);
            rd(`ADC_ADDR_MODE, v & 8'h7e);
            wr(`ADC_ADDR_TIMING, v & 8'h8f);
            rd(`ADC_ADDR_TIMING, v & 8'h8f);
        end
        wr(`ADC_ADDR_MODE, 8'h00);
        acc(1'b1, `ADC_ADDR_MODE, 8'hff, 8'h05);
        rd(`ADC_ADDR_MODE, 8'h04);
        wr(`ADC_ADDR_TRIG_SRC, 8'hff);
        rd(`ADC_ADDR_TRIG_SRC, 8'h03);
        foreach (codes[i])
        begin
            n = (codes[i] + 1) * 31;
            m = i[0] ? 8'h90 : 8'h80;
            wr(`ADC_ADDR_TIMING, 8'h80 | 8'(codes[i]));
            note_start(stab[i], stab[i] + 3);
            note_start(n, n);
            exp_done.push_back(n);
            wr(`ADC_ADDR_MODE, m);
            drain(stab[i] + n + 20);
            rd(`ADC_ADDR_MODE, m | 8'h01);
            note_start(1, 2);
            note_start(n, n);
            exp_done.push_back(n);
            wr(`ADC_ADDR_CHANNEL, 8'h00);
            drain(n + 20);
            stop();
        end
        wr(`ADC_ADDR_TIMING, 8'h80);
        note_start(16, 19);
        exp_done.push_back(31);
        wr(`ADC_ADDR_MODE, 8'hb0);
        repeat (120) @(posedge clk);
        rd(`ADC_ADDR_MODE, 8'hb0);
        stop();
        wr(`ADC_ADDR_TRIG_SRC, 8'h01);
        wr(`ADC_ADDR_MODE, 8'hb2);
        repeat (30) @(posedge clk);
        rd(`ADC_ADDR_MODE, 8'hb2);
        pulse(1'b1);
        note_start(1, 3);
        pulse(1'b0);
        drain(10);
        wr(`ADC_ADDR_CMP_THR, 8'h5a);
        repeat (3) @(posedge clk);
        rd(`ADC_ADDR_MODE, 8'hb2);
        repeat (40) @(posedge clk);
        wr(`ADC_ADDR_TRIG_SRC, 8'h02);
        note_start(1, 3);
        exp_done.push_back(31);
        pulse(1'b1);
        drain(10);
        repeat (40) @(posedge clk);
        wr(`ADC_ADDR_TRIG_SRC, 8'h00);
        for (int e = 0; e < 4; e++)
        begin
            wr(`ADC_ADDR_MODE, 8'hb2 | 8'(e << 2));
            edge_pin(1'b1, e[1]);
            edge_pin(1'b0, e[0]);
        end
        stop();
        if (exp_done.size() != 0)
            fail("conversion done missing");
        print_verdict();
    end
endmodule : tb
